// ==== src/rbs_regs.vh ====
// constants for the reset and boot select block
`ifndef RBS_REGS_VH
`define RBS_REGS_VH

// ********************************************************************
// boot mode encodings
// ********************************************************************
`define RBS_MODE_USER       3'h0
`define RBS_MODE_BOOT_LOADER 3'h1
`define RBS_MODE_DEBUG      3'h2
`define RBS_MODE_JTAG_USER  3'h3
`define RBS_MODE_UNDEF      3'h7
`define RBS_PC_START        16'h0000

// ********************************************************************
// reset cause bit positions
// ********************************************************************
`define RBS_CAUSE_POR       0
`define RBS_CAUSE_HW        1
`define RBS_CAUSE_WDT       2
`define RBS_CAUSE_WAKE      3
`define RBS_CAUSE_BROWN     4

// ********************************************************************
// timing
// ********************************************************************
`define RBS_CLK_NS          100
`define RBS_PIN_MIN_NS      100
`define RBS_PIN_MIN_CYC     ((`RBS_PIN_MIN_NS + `RBS_CLK_NS - 1) / `RBS_CLK_NS)
`define RBS_STRETCH_CYC     4

`endif

// ==== src/rbs_sync3.v ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module rbs_sync3 #(
    parameter RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire clock,
    input  wire rst_n,
    // data
    input  wire din,
    output reg  dout_q
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first stage feeds only the second; output moves once 2 and 3 agree
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q   <= RESET_VAL;
            s2_q   <= RESET_VAL;
            s3_q   <= RESET_VAL;
            dout_q <= RESET_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout_q <= s3_q;
            end
        end
    end

endmodule // rbs_sync3

`default_nettype wire

// ==== src/rbs_reset_boot.v ====
// reset merging and boot mode selection
`timescale 1ns/1ps
`default_nettype none
`include "rbs_regs.vh"

module rbs_reset_boot #(
    parameter STRETCH = `RBS_STRETCH_CYC
) (
    // clock and power-on reset
    input  wire        clock,
    input  wire        rstn,
    // reset sources and power-down request
    input  wire        reset_pin_n,
    input  wire        watchdog_timer_rst,
    input  wire        wake_rst,
    input  wire        brownout_rst,
    input  wire        power_down,
    // boot straps and flash protection
    input  wire        boot_mode_select_pin,
    input  wire        tms_strap,
    input  wire        port0_bit0_strap,
    input  wire        flash_protected,
    // reset outputs
    output wire        sys_rst_n,
    output reg  [4:0]  reset_cause_q,
    output reg         ram_valid_q,
    output reg         embedded_voltage_regulator_on_q,
    // boot outputs
    output reg  [2:0]  boot_mode_q,
    output reg  [15:0] pc_start_q,
    output reg         jtag_active_q,
    output reg         debug_refused_q
);

    // ****************************************************************
    // reset release of the block itself
    // ****************************************************************
    reg rst_a_q;
    reg rst_b_q;
    wire rst_n;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_n = rst_b_q;

    // ****************************************************************
    // pin inputs through synchronisers
    // ****************************************************************
    wire pin_n_s;
    wire mode_pin_s;
    wire tms_s;
    wire port0_s;

    rbs_sync3 #(.RESET_VAL(1'b1)) u_pin (
        .clock  (clock),
        .rst_n  (rst_n),
        .din    (reset_pin_n),
        .dout_q (pin_n_s)
    );
    // straps need four edges to settle; the stretch count covers that
    rbs_sync3 #(.RESET_VAL(1'b0)) u_mode_pin (
        .clock  (clock),
        .rst_n  (rst_n),
        .din    (boot_mode_select_pin),
        .dout_q (mode_pin_s)
    );
    rbs_sync3 #(.RESET_VAL(1'b0)) u_tms (
        .clock  (clock),
        .rst_n  (rst_n),
        .din    (tms_strap),
        .dout_q (tms_s)
    );
    rbs_sync3 #(.RESET_VAL(1'b0)) u_port0 (
        .clock  (clock),
        .rst_n  (rst_n),
        .din    (port0_bit0_strap),
        .dout_q (port0_s)
    );

    // ****************************************************************
    // source merge and reset stretch
    // ****************************************************************
    // merge all sources; power-on is the block reset itself
    wire hw_act  = ~pin_n_s;
    // watchdog request joins the merge like any other source
    wire any_src = hw_act | watchdog_timer_rst | wake_rst | brownout_rst;

    // counter is eight bits wide, so the stretch is cut to its low eight bits
    localparam [7:0] STRETCH_C = STRETCH[7:0];

    // power-on stays pending until the first release of the block
    reg        in_rst_q;
    reg        por_pend_q;
    reg        hw_seen_q;
    reg [4:0]  seen_q;
    reg [7:0]  cnt_q;

    // hold while active, count out, release on the clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_rst_q   <= 1'b1;
            por_pend_q <= 1'b1;
            hw_seen_q  <= 1'b0;
            seen_q     <= 5'h01;
            cnt_q      <= 8'h00;
        end else if (any_src) begin
            in_rst_q  <= 1'b1;
            cnt_q     <= 8'h00;
            hw_seen_q <= hw_seen_q | hw_act;
            seen_q    <= seen_q | {brownout_rst, wake_rst,
                                   watchdog_timer_rst, hw_act, 1'b0};
        end else if (in_rst_q) begin
            if (cnt_q >= STRETCH_C) begin
                in_rst_q   <= 1'b0;
                por_pend_q <= 1'b0;
                hw_seen_q  <= 1'b0;
                seen_q     <= 5'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    assign sys_rst_n = ~in_rst_q;

    // last cycle of a reset: no source left and the stretch count reached
    wire rst_end = in_rst_q & ~any_src & (cnt_q >= STRETCH_C);

    // ****************************************************************
    // boot decode
    // ****************************************************************
    // three straps decoded together
    reg [2:0] mode_d;
    reg       refuse_d;
    always @* begin
        // defaults keep the process free of latches
        mode_d   = `RBS_MODE_UNDEF;
        refuse_d = 1'b0;
        case ({tms_s, port0_s})
            2'b00, 2'b01: begin
                mode_d = mode_pin_s ? `RBS_MODE_USER
                                    : `RBS_MODE_BOOT_LOADER;
            end
            2'b10: begin
                if (mode_pin_s) begin
                    mode_d = `RBS_MODE_JTAG_USER;
                end else if (flash_protected) begin
                    // debug refused, fall back to user
                    mode_d   = `RBS_MODE_USER;
                    refuse_d = 1'b1;
                end else begin
                    mode_d = `RBS_MODE_DEBUG;
                end
            end
            default: begin
                mode_d = `RBS_MODE_UNDEF;
            end
        endcase
    end

    // latch at reset end only after power-on or pin reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boot_mode_q     <= `RBS_MODE_UNDEF;
            pc_start_q      <= `RBS_PC_START;
            jtag_active_q   <= 1'b0;
            debug_refused_q <= 1'b0;
        // other reset types leave the earlier selection in place
        end else if (rst_end && (por_pend_q || hw_seen_q)) begin
            boot_mode_q     <= mode_d;
            pc_start_q      <= `RBS_PC_START;
            jtag_active_q   <= (mode_d == `RBS_MODE_JTAG_USER) ||
                               (mode_d == `RBS_MODE_DEBUG);
            debug_refused_q <= refuse_d;
        end
    end

    // ****************************************************************
    // per-type effects on ram and regulator
    // ****************************************************************
    // cause is captured at release so software sees the last reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reset_cause_q                   <= 5'h01;
            ram_valid_q                     <= 1'b0;
            embedded_voltage_regulator_on_q <= 1'b1;
        end else begin
            if (rst_end) begin
                reset_cause_q <= seen_q;
                ram_valid_q <= ~seen_q[`RBS_CAUSE_POR] &
                               ~seen_q[`RBS_CAUSE_BROWN] & ram_valid_q |
                               (~seen_q[`RBS_CAUSE_POR] &
                                ~seen_q[`RBS_CAUSE_BROWN] &
                                (seen_q[`RBS_CAUSE_WAKE] |
                                 seen_q[`RBS_CAUSE_WDT] |
                                 seen_q[`RBS_CAUSE_HW]) & ram_valid_q);
            end else if (!in_rst_q) begin
                // ram becomes trusted once software runs
                ram_valid_q <= 1'b1;
            end
            // wake turns regulator on; watchdog no effect
            if (wake_rst) begin
                embedded_voltage_regulator_on_q <= 1'b1;
            end else if (power_down && !in_rst_q) begin
                embedded_voltage_regulator_on_q <= 1'b0;
            end
        end
    end

    // the pin path never looks at power_down, so power-down cannot mask it

endmodule // rbs_reset_boot

`default_nettype wire

// ==== verification/rbs_rb_asserts.sv ====
// port assertions for the reset and boot select block
`timescale 1ns/1ps
`default_nettype none

module rbs_rb_asserts (
    // clock and sources
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        reset_pin_n,
    input wire logic        watchdog_timer_rst,
    input wire logic        wake_rst,
    input wire logic        brownout_rst,
    input wire logic        power_down,
    // straps
    input wire logic        boot_mode_select_pin,
    input wire logic        tms_strap,
    input wire logic        port0_bit0_strap,
    input wire logic        flash_protected,
    // outputs
    input wire logic        sys_rst_n,
    input wire logic        ram_valid_q,
    input wire logic        embedded_voltage_regulator_on_q,
    input wire logic [4:0]  reset_cause_q,
    input wire logic [2:0]  boot_mode_q,
    input wire logic [15:0] pc_start_q,
    input wire logic        jtag_active_q,
    input wire logic        debug_refused_q
);
    // ********
    // checks
    // ********
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence rel_s; $rose(sys_rst_n); endsequence
    sequence pin_s; !reset_pin_n [*2]; endsequence
    src_rst_a: assert property (
        (watchdog_timer_rst || wake_rst || brownout_rst) |=> !sys_rst_n)
        else $error("source did not reset");
    rel_late_a: assert property (
        rel_s |-> !$past(watchdog_timer_rst) && !$past(wake_rst)
        && !$past(brownout_rst)) else $error("early release");
    pin_rst_a: assert property (pin_s |-> ##[1:8] !sys_rst_n)
        else $error("pin reset missed");
    boot_keep_a: assert property (
        sys_rst_n && $past(sys_rst_n) |-> $stable(boot_mode_q))
        else $error("boot mode moved");
    debug_block_a: assert property (
        debug_refused_q |-> boot_mode_q == 3'h0) else $error("refusal mode");
    jtag_on_a: assert property (sys_rst_n |-> jtag_active_q ==
        (boot_mode_q == 3'h2 || boot_mode_q == 3'h3)) else $error("jtag");
    pc_zero_a: assert property (pc_start_q == 16'h0000)
        else $error("start address");
    watchdog_keep_a: assert property (
        rel_s ##0 reset_cause_q == 5'h04 |-> $stable(ram_valid_q)
        && $stable(embedded_voltage_regulator_on_q))
        else $error("watchdog reset changed state");
    brown_ram_a: assert property (
        rel_s ##0 reset_cause_q[4] |-> !ram_valid_q) else $error("ram");
    wake_reg_a: assert property (
        rel_s ##0 reset_cause_q[3] |-> embedded_voltage_regulator_on_q)
        else $error("regulator");
endmodule // rbs_rb_asserts

bind rbs_reset_boot rbs_rb_asserts i_chk (
    .clock                           (clock),
    .rstn                            (rstn),
    .reset_pin_n                     (reset_pin_n),
    .watchdog_timer_rst              (watchdog_timer_rst),
    .wake_rst                        (wake_rst),
    .brownout_rst                    (brownout_rst),
    .power_down                      (power_down),
    .boot_mode_select_pin            (boot_mode_select_pin),
    .tms_strap                       (tms_strap),
    .port0_bit0_strap                (port0_bit0_strap),
    .flash_protected                 (flash_protected),
    .sys_rst_n                       (sys_rst_n),
    .ram_valid_q                     (ram_valid_q),
    .embedded_voltage_regulator_on_q (embedded_voltage_regulator_on_q),
    .reset_cause_q                   (reset_cause_q),
    .boot_mode_q                     (boot_mode_q),
    .pc_start_q                      (pc_start_q),
    .jtag_active_q                   (jtag_active_q),
    .debug_refused_q                 (debug_refused_q)
);
`default_nettype wire

// ==== verification/rbs_ext_model.sv ====
// external reset circuit and boot strap model
`timescale 1ns/1ps
`default_nettype none

module rbs_ext_model (
    // clock
    input  wire logic       clock,
    // pin and straps {mode pin, tms, port0 bit0}
    output var  logic       reset_pin_n,
    output var  logic [2:0] strap
);
    // pull-up keeps the pin high when released
    initial begin
        reset_pin_n = 1'b1;
        strap = 3'h0;
    end
    task automatic set_strap(input logic [2:0] s);
        @(posedge clock);
        #5 strap = s;
    endtask
    task automatic pin_reset(input logic [2:0] s);
        set_strap(s);
        reset_pin_n = 1'b0;
        repeat (3) @(posedge clock);
        #5 reset_pin_n = 1'b1;
    endtask
endmodule // rbs_ext_model
`default_nettype wire

// ==== verification/rbs_reset_boot_tb_top.sv ====
// self-checking bench for the reset and boot select block
`timescale 1ns/1ps
`default_nettype none

module rbs_reset_boot_tb_top;
    logic        clock, rstn, wdog, wake, brown, pd, fp, reset_pin_n;
    logic        sys_rst_n, ram_v, reg_on, jtag, refd, reg_m;
    logic [2:0]  strap, mode, mode_m;
    logic [4:0]  cause;
    logic [15:0] pc;
    int          errors, n_checks;

    rbs_ext_model i_ext (.clock(clock), .reset_pin_n(reset_pin_n),
        .strap(strap));
    rbs_reset_boot i_dut (.clock(clock), .rstn(rstn),
        .reset_pin_n(reset_pin_n), .watchdog_timer_rst(wdog),
        .wake_rst(wake), .brownout_rst(brown), .power_down(pd),
        .boot_mode_select_pin(strap[2]), .tms_strap(strap[1]),
        .port0_bit0_strap(strap[0]), .flash_protected(fp),
        .sys_rst_n(sys_rst_n), .reset_cause_q(cause), .ram_valid_q(ram_v),
        .embedded_voltage_regulator_on_q(reg_on), .boot_mode_q(mode),
        .pc_start_q(pc), .jtag_active_q(jtag), .debug_refused_q(refd));

    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // boot decode model, straps {mode pin, tms, port0 bit0}
    function automatic logic [2:0] exp_mode(input logic [2:0] s, logic f);
        if (!s[1]) return s[2] ? 3'h0 : 3'h1;
        if (s[0]) return 3'h7;
        return s[2] ? 3'h3 : (f ? 3'h0 : 3'h2);
    endfunction
    // bounded wait for the internal reset level
    task automatic wait_lvl(input logic v);
        for (int i = 0; i < 40; i++) begin
            @(posedge clock);
            #1;
            if (sys_rst_n === v) break;
        end
        check("sys_rst_n", sys_rst_n, v);
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #300000 errors++;
        complete_run();
    end
    initial begin
        int k;
        errors = 0;
        n_checks = 0;
        rstn = 1'b0;
        {wdog, wake, brown, pd, fp} = 5'h00;
        k = $urandom(80);
        repeat (12) @(posedge clock);
        #5 rstn = 1'b1;
        wait_lvl(1'b1);
        check("cause", cause, 5'h01);
        check("mode", mode, exp_mode(3'h0, 1'b0));
        // every strap code with and without flash protection
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            #5 {fp, pd} = {i[3], 1'($urandom)};
            i_ext.pin_reset(i[2:0]);
            pd = 1'b0;
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            mode_m = exp_mode(i[2:0], i[3]);
            check("mode", mode, mode_m);
            check("refused", refd, i[2:0] == 3'h2 && i[3]);
            check("jtag", jtag, mode_m == 3'h2 || mode_m == 3'h3);
            check("pc", pc, 16'h0000);
            check("cause", cause, 5'h02);
            check("ram", ram_v, 1'b1);
        end
        // wake, watchdog, brownout with straps moved meanwhile
        for (k = 0; k < 3; k++) begin
            i_ext.set_strap(3'($urandom));
            // moved straps settle before the next reset starts
            repeat (4) @(posedge clock);
            #5 pd = 1'b1;
            @(posedge clock);
            #5 pd = 1'b0;
            {wake, wdog, brown} = 3'h4 >> k;
            reg_m = (k == 0);
            repeat (2) @(posedge clock);
            #5 {wake, wdog, brown} = 3'h0;
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            check("cause", cause, k == 2 ? 5'h10 : 5'h08 >> k);
            check("mode", mode, mode_m);
            check("ram", ram_v, k != 2);
            if (k < 2) check("regulator", reg_on, reg_m);
        end
        // a later power-on reset in mid-run takes the fresh straps
        i_ext.set_strap(3'h4);
        rstn = 1'b0;
        repeat (3) @(posedge clock);
        #5 rstn = 1'b1;
        wait_lvl(1'b1);
        check("cause", cause, 5'h01);
        check("mode", mode, exp_mode(3'h4, fp));
        check("ram", ram_v, 1'b0);
        check("jtag", jtag, 1'b0);
        complete_run();
    end
endmodule // rbs_reset_boot_tb_top
`default_nettype wire
